// file: ocir_option_config.sv
/*
 Option loader and interrupt routing for a small controller: latches the
 programmed option word at reset, sequences the boot wait, routes pin
 interrupts, decodes timer, oscillator and pin settings, and keeps the
 global interrupt enable. Registers sit on a 32-bit classic Wishbone slave.
 Assumes all inputs synchronous to clk; slowOscTick marks one low-speed
 oscillator period.
*/
// Function
// - Protection option set makes program readback return zeros, else real content.
// - Boot wait is 3000 or 45 slow oscillator cycles, chosen by option.
// - Interrupt bit 0 follows port_a_pin0 or port_b_pin5 by first source option.
// - Interrupt bit 1 follows port_b_pin0 or port_a_pin4 by second source option.
// - Comparator request bit 2 on both edges, rising only, or falling only; it never reaches irqToCpu.
// - Gate option lets comparator output control PWM output, else independent.
// - Clock field 0010 selects 16 MHz or doubled 32 MHz timer clock by option.
// - Scale bit 7 set gives 6 or 7 bit PWM by resolution option.
// - Output field 1 puts first timer on port_b_pin0 or port_b_pin2.
// - Crystal range field: 01 low, 10 middle, 11 high frequency.
// - Crystal control bit 7 set enables the crystal oscillator.
// - Clock mode bit 0 with port_a_pin5 input makes it active-low reset.
// - port_a_pin5 as output only pulls low, never drives high.
// - Input pin is digital input only with its enable bit.
// - Taking an interrupt jumps to service and clears global enable.
// - Return from interrupt restores global enable.
// - Enable and request registers start undefined; software writes both first (here reset clears both to zero).
// - Global disable blocks every interrupt request from the processor.
`timescale 1ns/1ns
module ocir_option_config #(
  parameter int BOOT_SLOW_CYC = ocir_pkg::OCIR_BOOT_SLOW_CYC,
  parameter int BOOT_FAST_CYC = ocir_pkg::OCIR_BOOT_FAST_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Programmed options and program store
  input wire logic [ocir_pkg::OCIR_OPT_WIDTH-1:0] optWord,
  input wire logic [31:0] romData,
  input wire logic slowOscTick,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Pins and unit inputs
  input wire logic portAPin0,
  input wire logic portAPin4,
  input wire logic portAPin5In,
  input wire logic portBPin0,
  input wire logic portBPin5,
  input wire logic [7:0] portAPins,
  input wire logic [7:0] portBPins,
  input wire logic comparatorOut,
  input wire logic pwmRaw,
  input wire logic tmrAOut,
  input wire logic irqTaken,
  // Outputs to core and units
  output logic bootDone,
  output logic irqToCpu,
  output logic [1:0] irqVector,
  output logic extResetN,
  output logic portAPin5Out,
  output logic portAPin5Oe,
  output logic pwmOut,
  output logic tmrOnPb0,
  output logic tmrOnPb2,
  output logic tmrAClk32M,
  output logic tmrBClk32M,
  output logic tmrAHirc,
  output logic tmrBHirc,
  output logic [2:0] tmrAPwmBits,
  output logic [2:0] tmrBPwmBits,
  output logic xoscEnable,
  output logic [1:0] xoscRange,
  output logic [7:0] portADigIn,
  output logic [7:0] portBDigIn
);
  import ocir_pkg::*;

  // ********************************************
  // State
  // ********************************************
  typedef enum logic [1:0] {
    OCIR_LOAD = 2'b00,
    OCIR_WAIT = 2'b01,
    OCIR_RUN = 2'b11
  } ocir_boot_e;

  typedef struct packed {
    ocir_boot_e boot;
    logic [11:0] waitCnt;
    logic [OCIR_OPT_WIDTH-1:0] opt;
    logic [1:0] inten;
    logic [2:0] intrq;
    logic gie;
    logic [7:0] tmaCtrl;
    logic [7:0] tmbCtrl;
    logic [7:0] tmaScale;
    logic [7:0] tmbScale;
    logic [7:0] xoscCtrl;
    logic [7:0] clkMode;
    logic [7:0] paDig;
    logic [7:0] pbDig;
    logic [7:0] paDir;
    logic [7:0] paOut;
    logic [1:0] pinPrev;
    logic cmpPrev;
    logic [31:0] rdat;
    logic ack;
    logic err;
  } ocir_state_s;

  ocir_state_s s_q;
  ocir_state_s s_d;
  logic [1:0] rstSync_q;
  logic rstN;

  initial begin
    if (BOOT_SLOW_CYC < 1 || BOOT_SLOW_CYC > 4095 || BOOT_FAST_CYC < 1 ||
        BOOT_FAST_CYC > BOOT_SLOW_CYC) begin
      $error("Boot wait counts out of range");
    end
  end

  // ********************************************
  // Reset release
  // ********************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];

  // ********************************************
  // Next state
  // ********************************************
  logic pin0Sel;
  logic pin1Sel;
  logic cmpEdge;
  logic busReq;
  logic [1:0] edgeOpt;
  logic [31:0] rd;
  logic known;

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.err = 1'b0;
    edgeOpt = {s_q.opt[OCIR_OPT_EDGE_HI], s_q.opt[OCIR_OPT_EDGE_LO]};
    pin0Sel = s_q.opt[OCIR_OPT_SRC0_PB5] ? portBPin5 : portAPin0;
    pin1Sel = s_q.opt[OCIR_OPT_SRC1_PA4] ? portAPin4 : portBPin0;
    unique case (edgeOpt)
      OCIR_EDGE_RISE: cmpEdge = comparatorOut & ~s_q.cmpPrev;
      OCIR_EDGE_FALL: cmpEdge = ~comparatorOut & s_q.cmpPrev;
      default: cmpEdge = comparatorOut ^ s_q.cmpPrev;
    endcase
    // Option latch happens once; software has no write path to it
    unique case (s_q.boot)
      OCIR_LOAD: begin
        s_d.opt = optWord;
        s_d.waitCnt = optWord[OCIR_OPT_BOOT_FAST] ? 12'(BOOT_FAST_CYC) :
                      12'(BOOT_SLOW_CYC);
        s_d.boot = OCIR_WAIT;
      end
      OCIR_WAIT: begin
        if (slowOscTick) begin
          s_d.waitCnt = s_q.waitCnt - 12'h001;
          if (s_q.waitCnt == 12'h001) begin
            s_d.boot = OCIR_RUN;
          end
        end
      end
      OCIR_RUN: begin
      end
      default: begin
        s_d.boot = OCIR_LOAD;
      end
    endcase
    s_d.pinPrev = {pin1Sel, pin0Sel};
    s_d.cmpPrev = comparatorOut;
    // Rising edges of the selected pins raise requests
    if (pin0Sel & ~s_q.pinPrev[0]) begin
      s_d.intrq[0] = 1'b1;
    end
    if (pin1Sel & ~s_q.pinPrev[1]) begin
      s_d.intrq[1] = 1'b1;
    end
    if (cmpEdge) begin
      s_d.intrq[2] = 1'b1;
    end
    if (irqTaken) begin
      s_d.gie = 1'b0;
    end
    busReq = wb_cyc_i & wb_stb_i & ~s_q.ack & ~s_q.err;
    known = 1'b1;
    rd = 32'h0000_0000;
    unique case (wb_adr_i)
      OCIR_ADR_OPTIONS: rd = 32'(s_q.opt);
      OCIR_ADR_INTEN: rd = {30'h0, s_q.inten};
      OCIR_ADR_INTRQ: rd = {29'h0, s_q.intrq};
      OCIR_ADR_CPUCTL: rd = {31'h0, s_q.gie};
      OCIR_ADR_TMA_CTRL: rd = {24'h0, s_q.tmaCtrl};
      OCIR_ADR_TMB_CTRL: rd = {24'h0, s_q.tmbCtrl};
      OCIR_ADR_TMA_SCALE: rd = {24'h0, s_q.tmaScale};
      OCIR_ADR_TMB_SCALE: rd = {24'h0, s_q.tmbScale};
      OCIR_ADR_XOSC_CTRL: rd = {24'h0, s_q.xoscCtrl};
      OCIR_ADR_CLKMODE: rd = {24'h0, s_q.clkMode};
      OCIR_ADR_PA_DIGIN: rd = {24'h0, s_q.paDig};
      OCIR_ADR_PB_DIGIN: rd = {24'h0, s_q.pbDig};
      OCIR_ADR_PA_DIR: rd = {24'h0, s_q.paDir};
      OCIR_ADR_PA_OUT: rd = {24'h0, s_q.paOut};
      OCIR_ADR_STATUS: rd = {30'h0, s_q.boot == OCIR_RUN, s_q.opt[OCIR_OPT_SECURE]};
      OCIR_ADR_ROM_READ: rd = s_q.opt[OCIR_OPT_SECURE] ? OCIR_READ_REFUSED : romData;
      default: known = 1'b0;
    endcase
    if (busReq) begin
      s_d.ack = known;
      s_d.err = ~known;
      s_d.rdat = rd;
      if (wb_we_i && known && wb_sel_i[0]) begin
        unique case (wb_adr_i)
          OCIR_ADR_INTEN: s_d.inten = wb_dat_i[1:0];
          // Write one to clear; a same-cycle event sets the flag only if it was clear before
          OCIR_ADR_INTRQ: s_d.intrq = s_d.intrq & ~(wb_dat_i[2:0] & s_q.intrq);
          OCIR_ADR_CPUCTL: begin
            if (wb_dat_i[OCIR_CPU_ENGINT] || wb_dat_i[OCIR_CPU_RETI]) begin
              s_d.gie = 1'b1;
            end
            if (wb_dat_i[OCIR_CPU_DISGINT]) begin
              s_d.gie = 1'b0;
            end
          end
          OCIR_ADR_TMA_CTRL: s_d.tmaCtrl = wb_dat_i[7:0];
          OCIR_ADR_TMB_CTRL: s_d.tmbCtrl = wb_dat_i[7:0];
          OCIR_ADR_TMA_SCALE: s_d.tmaScale = wb_dat_i[7:0];
          OCIR_ADR_TMB_SCALE: s_d.tmbScale = wb_dat_i[7:0];
          OCIR_ADR_XOSC_CTRL: s_d.xoscCtrl = wb_dat_i[7:0];
          OCIR_ADR_CLKMODE: s_d.clkMode = wb_dat_i[7:0];
          OCIR_ADR_PA_DIGIN: s_d.paDig = wb_dat_i[7:0];
          OCIR_ADR_PB_DIGIN: s_d.pbDig = wb_dat_i[7:0];
          OCIR_ADR_PA_DIR: s_d.paDir = wb_dat_i[7:0];
          OCIR_ADR_PA_OUT: s_d.paOut = wb_dat_i[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Enable and request flags start cleared here only to keep them defined
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_q <= '{boot: OCIR_LOAD, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************
  // Outputs
  // ********************************************
  assign wb_ack_o = s_q.ack;
  assign wb_err_o = s_q.err;
  assign wb_dat_o = s_q.rdat;
  assign bootDone = (s_q.boot == OCIR_RUN);
  assign irqVector = s_q.inten & s_q.intrq[1:0];
  assign irqToCpu = s_q.gie & bootDone & (|irqVector);
  assign pwmOut = s_q.opt[OCIR_OPT_GATE_PWM] ? (pwmRaw & comparatorOut) : pwmRaw;
  assign tmrAHirc = s_q.tmaCtrl[OCIR_TMC_CLK_HI:OCIR_TMC_CLK_LO] == OCIR_TMC_CLK_HIRC;
  assign tmrBHirc = s_q.tmbCtrl[OCIR_TMC_CLK_HI:OCIR_TMC_CLK_LO] == OCIR_TMC_CLK_HIRC;
  assign tmrAClk32M = tmrAHirc & s_q.opt[OCIR_OPT_TMR_32M];
  assign tmrBClk32M = tmrBHirc & s_q.opt[OCIR_OPT_TMR_32M];
  assign tmrAPwmBits = !s_q.tmaScale[OCIR_TMS_PWM] ? 3'h0 :
                       (s_q.opt[OCIR_OPT_TMR_7BIT] ? 3'h7 : 3'h6);
  assign tmrBPwmBits = !s_q.tmbScale[OCIR_TMS_PWM] ? 3'h0 :
                       (s_q.opt[OCIR_OPT_TMR_7BIT] ? 3'h7 : 3'h6);
  logic tmrRouted;
  assign tmrRouted = s_q.tmaCtrl[OCIR_TMC_OUT_HI:OCIR_TMC_OUT_LO] == OCIR_TMC_OUT_ALT;
  assign tmrOnPb0 = tmrRouted & s_q.opt[OCIR_OPT_OUT_PB0] & tmrAOut;
  assign tmrOnPb2 = tmrRouted & ~s_q.opt[OCIR_OPT_OUT_PB0] & tmrAOut;
  assign xoscRange = s_q.xoscCtrl[OCIR_XOSC_RNG_HI:OCIR_XOSC_RNG_LO];
  assign xoscEnable = s_q.xoscCtrl[OCIR_XOSC_EN];
  assign extResetN = (s_q.clkMode[OCIR_CLOCK_MODE_REG_RSTPIN] & ~s_q.paDir[5]) ?
                     portAPin5In : 1'b1;
  // Open drain: the pin is only ever pulled low
  assign portAPin5Out = 1'b0;
  assign portAPin5Oe = s_q.paDir[5] & ~s_q.paOut[5];
  assign portADigIn = portAPins & s_q.paDig & ~s_q.paDir;
  assign portBDigIn = portBPins & s_q.pbDig;

endmodule

// file: ocir_option_config_bench.sv
/*
 Self-checking bench for the option loader, random options from a fixed seed.
 Assumes the design package is compiled first; boot counts shortened to 8/2.
*/
`timescale 1ns/1ns
module ocir_option_config_bench;
  import ocir_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, slowOscTick = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic pin5In = 1'b1, cmpOut = 1'b0, pwmRaw = 1'b0, tmrAOut = 1'b0, irqTaken = 1'b0, rdErr;
  logic [9:0] optWord = 10'h000;
  logic [7:0] wbAdr = 8'h00, paPins = 8'h00, pbPins = 8'h00;
  logic [31:0] romData = 32'h0, wbDatI = 32'h0, wbDatO, rdData;
  logic [3:0] pinV = 4'h0;
  logic wbAck, wbErr, bootDone, irqToCpu, extResetN, pin5Out, pin5Oe, pwmOut, tmrOnPb0, tmrOnPb2;
  logic tmrAClk32M, tmrBClk32M, xoscEnable;
  logic [1:0] irqVector, xoscRange;
  logic [2:0] tmrABits, tmrBBits;
  logic [7:0] paDig, pbDig;
  int numErrors = 0, totalChecks = 0, cycles = 0, seed = 73;

  ocir_option_config #(.BOOT_SLOW_CYC(8), .BOOT_FAST_CYC(2)) dut_u (
    .clk(clk), .nrst(nrst), .optWord(optWord), .romData(romData), .slowOscTick(slowOscTick),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .wb_err_o(wbErr),
    .portAPin0(pinV[0]), .portAPin4(pinV[1]), .portAPin5In(pin5In), .portBPin0(pinV[2]),
    .portBPin5(pinV[3]), .portAPins(paPins), .portBPins(pbPins), .comparatorOut(cmpOut),
    .pwmRaw(pwmRaw), .tmrAOut(tmrAOut), .irqTaken(irqTaken), .bootDone(bootDone),
    .irqToCpu(irqToCpu), .irqVector(irqVector), .extResetN(extResetN), .portAPin5Out(pin5Out),
    .portAPin5Oe(pin5Oe), .pwmOut(pwmOut), .tmrOnPb0(tmrOnPb0), .tmrOnPb2(tmrOnPb2),
    .tmrAClk32M(tmrAClk32M), .tmrBClk32M(tmrBClk32M), .tmrAHirc(), .tmrBHirc(),
    .tmrAPwmBits(tmrABits), .tmrBPwmBits(tmrBBits), .xoscEnable(xoscEnable),
    .xoscRange(xoscRange), .portADigIn(paDig), .portBDigIn(pbDig));

  initial begin
    forever #25 clk = ~clk;
  end

  // ****************************************
  // Tasks and expectations
  // ****************************************
  task automatic finishTest();
    $display("Checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      finishTest();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Classic cycle: request held until ack or err is sampled, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 20);
    if (wbAck !== 1'b1 && wbErr !== 1'b1) numErrors++;
    rdData = wbDatO;
    rdErr = wbErr;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] expRom(input logic [9:0] o);
    return o[OCIR_OPT_SECURE] ? OCIR_READ_REFUSED : romData;
  endfunction

  function automatic logic [2:0] expBits(input logic [9:0] o);
    return o[OCIR_OPT_TMR_7BIT] ? 3'h7 : 3'h6;
  endfunction

  // ****************************************
  // Main sequence, one reset per option set
  // ****************************************
  initial begin
    logic [9:0] o;
    logic [31:0] k;
    int n, sel, oth;
    for (int i = 0; i < 4; i++) begin
      o = 10'($random(seed));
      o[5:4] = 2'(i % 3);
      o[1:0] = {i[0], i[1]};
      romData <= $random(seed);
      pinV <= 4'h0;
      cmpOut <= 1'b0;
      nrst <= 1'b0;
      optWord <= o;
      tick(5);
      nrst <= 1'b1;
      tick(4);
      n = 0;
      while (bootDone !== 1'b1 && n < 20) begin
        slowOscTick <= 1'b1;
        n++;
        tick(1);
        slowOscTick <= 1'b0;
        tick(3);
      end
      check("boot pulses", 32'(n), o[1] ? 32'h2 : 32'h8);
      optWord <= ~o;
      wr(OCIR_ADR_OPTIONS, {22'h0, ~o});
      rd(OCIR_ADR_OPTIONS);
      check("options", rdData, {22'h0, o});
      rd(OCIR_ADR_ROM_READ);
      check("readback", rdData, expRom(o));
      rd(8'h40);
      check("unmapped", 32'(rdErr), 32'h1);
      wr(OCIR_ADR_TMA_CTRL, 32'h24);
      wr(OCIR_ADR_TMB_CTRL, 32'h20);
      wr(OCIR_ADR_TMA_SCALE, 32'h80);
      wr(OCIR_ADR_TMB_SCALE, 32'h80);
      tmrAOut <= 1'b1;
      tick(1);
      check("timer clk", 32'({tmrAClk32M, tmrBClk32M}), 32'({2{o[7]}}));
      check("pwm bits", 32'({tmrABits, tmrBBits}), 32'({2{expBits(o)}}));
      check("timer pin", 32'({tmrOnPb0, tmrOnPb2}), 32'({o[9], !o[9]}));
      wr(OCIR_ADR_TMA_CTRL, 32'h0);
      wr(OCIR_ADR_TMA_SCALE, 32'h0);
      check("timer off", 32'({tmrAClk32M, tmrABits}), 32'h0);
      wr(OCIR_ADR_PA_DIR, 32'h0);
      wr(OCIR_ADR_PA_DIGIN, 32'h0);
      // System clock never moves to the crystal here
      for (int r = 1; r < 4; r++) begin
        wr(OCIR_ADR_XOSC_CTRL, 32'((r % 2) * 128 + r * 32));
        check("crystal", 32'({xoscEnable, xoscRange}), 32'((r % 2) * 4 + r));
      end
      k = $random(seed);
      paPins <= 8'($random(seed));
      pbPins <= 8'($random(seed));
      wr(OCIR_ADR_PA_DIR, 32'h0);
      wr(OCIR_ADR_PA_DIGIN, 32'(k[7:0]));
      wr(OCIR_ADR_PB_DIGIN, 32'(k[15:8]));
      check("digital in", 32'({paDig, pbDig}), 32'({paPins & k[7:0], pbPins & k[15:8]}));
      wr(OCIR_ADR_CLKMODE, 32'h1);
      pin5In <= 1'b0;
      tick(1);
      check("reset pin", 32'(extResetN), 32'h0);
      wr(OCIR_ADR_CLKMODE, 32'h0);
      check("reset pin off", 32'(extResetN), 32'h1);
      pin5In <= 1'b1;
      wr(OCIR_ADR_PA_DIR, 32'h20);
      wr(OCIR_ADR_PA_OUT, 32'h0);
      check("pin5 low", 32'({pin5Oe, pin5Out}), 32'h2);
      wr(OCIR_ADR_PA_OUT, 32'h20);
      check("pin5 float", 32'({pin5Oe, pin5Out}), 32'h0);
      pwmRaw <= 1'b1;
      tick(1);
      check("pwm gated", 32'(pwmOut), 32'(!o[OCIR_OPT_GATE_PWM]));
      wr(OCIR_ADR_INTEN, 32'h3);
      wr(OCIR_ADR_INTRQ, 32'h7);
      wr(OCIR_ADR_CPUCTL, 32'h2);
      cmpOut <= 1'b1;
      tick(3);
      rd(OCIR_ADR_INTRQ);
      check("cmp rise", 32'(rdData[2]), 32'(o[5:4] != OCIR_EDGE_FALL));
      wr(OCIR_ADR_INTRQ, 32'h4);
      cmpOut <= 1'b0;
      tick(3);
      rd(OCIR_ADR_INTRQ);
      check("cmp fall", 32'(rdData[2]), 32'(o[5:4] != OCIR_EDGE_RISE));
      for (int j = 0; j < 2; j++) begin
        sel = j ? (o[3] ? 1 : 2) : (o[2] ? 3 : 0);
        oth = j ? (o[3] ? 2 : 1) : (o[2] ? 0 : 3);
        pinV[oth] <= 1'b1;
        tick(3);
        check("other pin", 32'(irqVector), 32'h0);
        pinV[sel] <= 1'b1;
        tick(3);
        check("irq route", 32'({irqToCpu, irqVector}), 32'(5 + j));
        // Core saves and restores its context itself
        irqTaken <= 1'b1;
        tick(1);
        irqTaken <= 1'b0;
        tick(1);
        check("irq entry", 32'(irqToCpu), 32'h0);
        wr(OCIR_ADR_CPUCTL, 32'h8);
        check("irq return", 32'(irqToCpu), 32'h1);
        wr(OCIR_ADR_CPUCTL, 32'h4);
        check("irq off", 32'(irqToCpu), 32'h0);
        wr(OCIR_ADR_INTRQ, 32'h7);
        wr(OCIR_ADR_CPUCTL, 32'h2);
      end
    end
    finishTest();
  end
endmodule

// file: ocir_option_config_chk.sv
/*
 Checker for the option loader: bus answers, interrupt gating and pin rules.
 Bound to ocir_option_config below; sees that module's ports only.
*/
`timescale 1ns/1ns
module ocir_option_config_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Pins and core
  input wire logic portAPin5In,
  input wire logic [7:0] portAPins,
  input wire logic [7:0] portBPins,
  input wire logic pwmRaw,
  input wire logic irqTaken,
  input wire logic bootDone,
  input wire logic irqToCpu,
  input wire logic [1:0] irqVector,
  input wire logic extResetN,
  input wire logic portAPin5Out,
  input wire logic pwmOut,
  input wire logic [7:0] portADigIn,
  input wire logic [7:0] portBDigIn
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_answer;
    wb_ack_o || wb_err_o;
  endsequence
  a_ack_timely: assert property (s_take |=> s_answer)
    else $error("bus request not answered next cycle");
  a_ack_single: assert property (s_answer |=> !wb_ack_o && !wb_err_o)
    else $error("bus answer longer than one cycle");
  a_boot_stays: assert property (bootDone |=> bootDone)
    else $error("boot done dropped while running");
  a_irq_blocked: assert property (irqTaken |=> !irqToCpu)
    else $error("interrupt still offered after entry");
  a_irq_cause: assert property (irqToCpu |-> bootDone && irqVector != 2'h0)
    else $error("interrupt without pending source");
  a_pin5_low: assert property (!portAPin5Out)
    else $error("pin five driven high");
  a_reset_pin: assert property (!extResetN |-> !portAPin5In)
    else $error("external reset without low pin");
  a_pwm_gate: assert property (!pwmRaw |-> !pwmOut)
    else $error("pwm output without pwm source");
  a_digin_mask: assert property (((portADigIn & ~portAPins) | (portBDigIn & ~portBPins)) == 8'h00)
    else $error("digital input shows a low pin high");
endmodule

bind ocir_option_config ocir_option_config_chk chk_u (
  .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .portAPin5In(portAPin5In), .portAPins(portAPins),
  .portBPins(portBPins), .pwmRaw(pwmRaw), .irqTaken(irqTaken), .bootDone(bootDone),
  .irqToCpu(irqToCpu), .irqVector(irqVector), .extResetN(extResetN),
  .portAPin5Out(portAPin5Out), .pwmOut(pwmOut), .portADigIn(portADigIn),
  .portBDigIn(portBDigIn));

// file: ocir_pkg.sv
/*
 Package for the option loader and interrupt routing block: register offsets,
 field positions, reset values, option bit layout and timing counts.
 Assumes a 20 MHz system clock and a 32-bit classic Wishbone register bus.
*/
package ocir_pkg;

  // ********************************************
  // Register byte offsets
  // ********************************************
  localparam logic [7:0] OCIR_ADR_OPTIONS = 8'h00;
  localparam logic [7:0] OCIR_ADR_INTEN = 8'h04;
  localparam logic [7:0] OCIR_ADR_INTRQ = 8'h08;
  localparam logic [7:0] OCIR_ADR_CPUCTL = 8'h0C;
  localparam logic [7:0] OCIR_ADR_TMA_CTRL = 8'h10;
  localparam logic [7:0] OCIR_ADR_TMB_CTRL = 8'h14;
  localparam logic [7:0] OCIR_ADR_TMA_SCALE = 8'h18;
  localparam logic [7:0] OCIR_ADR_TMB_SCALE = 8'h1C;
  localparam logic [7:0] OCIR_ADR_XOSC_CTRL = 8'h20;
  localparam logic [7:0] OCIR_ADR_CLKMODE = 8'h24;
  localparam logic [7:0] OCIR_ADR_PA_DIGIN = 8'h28;
  localparam logic [7:0] OCIR_ADR_PB_DIGIN = 8'h2C;
  localparam logic [7:0] OCIR_ADR_PA_DIR = 8'h30;
  localparam logic [7:0] OCIR_ADR_PA_OUT = 8'h34;
  localparam logic [7:0] OCIR_ADR_STATUS = 8'h38;
  localparam logic [7:0] OCIR_ADR_ROM_READ = 8'h3C;

  // ********************************************
  // Option word bit positions
  // ********************************************
  localparam int OCIR_OPT_SECURE = 0;
  localparam int OCIR_OPT_BOOT_FAST = 1;
  localparam int OCIR_OPT_SRC0_PB5 = 2;
  localparam int OCIR_OPT_SRC1_PA4 = 3;
  localparam int OCIR_OPT_EDGE_LO = 4;
  localparam int OCIR_OPT_EDGE_HI = 5;
  localparam int OCIR_OPT_GATE_PWM = 6;
  localparam int OCIR_OPT_TMR_32M = 7;
  localparam int OCIR_OPT_TMR_7BIT = 8;
  localparam int OCIR_OPT_OUT_PB0 = 9;
  localparam int OCIR_OPT_WIDTH = 10;

  // Comparator edge encodings
  localparam logic [1:0] OCIR_EDGE_ALL = 2'h0;
  localparam logic [1:0] OCIR_EDGE_RISE = 2'h1;
  localparam logic [1:0] OCIR_EDGE_FALL = 2'h2;

  // ********************************************
  // Register fields
  // ********************************************
  localparam int OCIR_TMC_CLK_HI = 7;
  localparam int OCIR_TMC_CLK_LO = 4;
  localparam logic [3:0] OCIR_TMC_CLK_HIRC = 4'h2;
  localparam int OCIR_TMC_OUT_HI = 3;
  localparam int OCIR_TMC_OUT_LO = 2;
  localparam logic [1:0] OCIR_TMC_OUT_ALT = 2'h1;
  localparam int OCIR_TMS_PWM = 7;
  localparam int OCIR_XOSC_EN = 7;
  localparam int OCIR_XOSC_RNG_HI = 6;
  localparam int OCIR_XOSC_RNG_LO = 5;
  localparam int OCIR_CLOCK_MODE_REG_RSTPIN = 0;
  localparam int OCIR_CPU_GIE = 0;
  localparam int OCIR_CPU_ENGINT = 1;
  localparam int OCIR_CPU_DISGINT = 2;
  localparam int OCIR_CPU_RETI = 3;
  localparam logic [7:0] OCIR_RST_BYTE = 8'h00;
  localparam logic [31:0] OCIR_READ_REFUSED = 32'h0000_0000;

  // ********************************************
  // Timing
  // ********************************************
  localparam int OCIR_BOOT_SLOW_CYC = 3000;
  localparam int OCIR_BOOT_FAST_CYC = 45;

endpackage
